// ### logic/otx_fifo.sv
// Payload buffer: parameterised FIFO with valid/ready on both sides
`timescale 1ns/10ps
module otx_fifo #(
	parameter int unsigned W = 1,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push)
				wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push && !flush)
			mem_q[wr_q] <= in_data;
	end
endmodule // otx_fifo

// ### logic/otx_pkg.sv
// Package: constants and types for the OOK transmitter state control
package otx_pkg;
	// Reference clock rate
	localparam int unsigned CLK_MHZ = 125;
	// Oscillator start-up and synthesizer tune intervals, microseconds
	localparam int unsigned T_XTAL_US = 400;
	localparam int unsigned T_TUNE_US = 370;
	localparam int unsigned XTAL_CYC = T_XTAL_US * CLK_MHZ;
	localparam int unsigned TUNE_CYC = T_TUNE_US * CLK_MHZ;
	// Stop interval: base plus step per select code, milliseconds
	localparam int unsigned T_MS_US = 1000;
	localparam int unsigned MS_CYC = T_MS_US * CLK_MHZ;
	localparam logic [6:0] STOP_BASE_MS = 7'h14;
	localparam logic [6:0] STOP_STEP_MS = 7'h0a;
	localparam int unsigned STOP_SEL_W = 3;
	// Payload sample period on the data pin, nanoseconds
	localparam int unsigned T_SAMPLE_NS = 1000;
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned SAMPLE_CYC = T_SAMPLE_NS / CLK_NS;
	// Payload buffer shape
	localparam int unsigned FIFO_W = 1;
	localparam int unsigned FIFO_DEPTH = 8;
	// Two-wire command words and the trigger arming reset value
	localparam logic [15:0] CMD_SOFT_RST = 16'hbd01;
	localparam logic [15:0] CMD_SER_DISABLE = 16'h8d02;
	localparam logic [15:0] CMD_SER_RESET = 16'h8d00;
	localparam logic EDGE_ARMED_RST = 1'h1;

	typedef enum logic [1:0] {
		OTX_SLEEP = 2'b00,
		OTX_OSC_STARTUP = 2'b01,
		OTX_TUNE = 2'b10,
		OTX_TRANSMIT = 2'b11
	} otx_state_e;

	typedef struct packed {
		logic trig_rising;
		logic [STOP_SEL_W-1:0] stop_sel;
	} otx_cfg_s;

	typedef struct packed {
		logic osc_en;
		logic synth_en;
		logic pa_en;
	} otx_rf_s;
endpackage

// ### logic/otx_tx_ctrl.sv
// OOK transmitter working-state control driven from the single data pin
`timescale 1ns/10ps
module otx_tx_ctrl #(
	parameter int unsigned XTAL_CYC = otx_pkg::XTAL_CYC,
	parameter int unsigned TUNE_CYC = otx_pkg::TUNE_CYC,
	parameter int unsigned MS_CYC = otx_pkg::MS_CYC,
	parameter int unsigned SAMPLE_CYC = otx_pkg::SAMPLE_CYC,
	parameter int unsigned FIFO_DEPTH = otx_pkg::FIFO_DEPTH
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic DATA_PIN,
	input wire otx_pkg::otx_cfg_s CFG,
	input wire logic CMD_VALID,
	input wire logic [15:0] CMD_WORD,
	input wire logic MOD_READY,
	output logic DATA_READY,
	output logic MOD_VALID,
	output logic MOD_BIT,
	output otx_pkg::otx_rf_s RF_EN,
	output otx_pkg::otx_state_e STATE,
	output logic CAL_START,
	output logic EDGE_ARMED
);
	import otx_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [6:0] stop_ms(input logic [STOP_SEL_W-1:0] sel);
		stop_ms = STOP_BASE_MS + 7'(sel) * STOP_STEP_MS;
	endfunction

	function automatic otx_rf_s rf_of(input otx_state_e s);
		rf_of.osc_en = (s != OTX_SLEEP);
		rf_of.synth_en = (s == OTX_TUNE) || (s == OTX_TRANSMIT);
		rf_of.pa_en = (s == OTX_TRANSMIT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State and timers

	otx_state_e state_q, state_d;
	otx_rf_s rf_q, rf_d;
	logic [31:0] timer_q, timer_d;
	logic [31:0] ms_div_q, ms_div_d;
	logic [6:0] low_ms_q, low_ms_d;
	logic [31:0] samp_q, samp_d;
	logic pin_q, edge_armed_q, edge_armed_d, cal_q, cal_d;
	logic trig_edge, soft_rst, ser_dis, ser_rst, stop_hit, samp_tick, ms_tick;
	logic push, flush, tx_exit;

	assign soft_rst = CMD_VALID && (CMD_WORD == CMD_SOFT_RST);
	assign ser_dis = CMD_VALID && (CMD_WORD == CMD_SER_DISABLE);
	assign ser_rst = CMD_VALID && (CMD_WORD == CMD_SER_RESET);
	// Pin is taken synchronous; one register suffices for edge detection
	assign trig_edge = CFG.trig_rising ? (DATA_PIN && !pin_q) : (!DATA_PIN && pin_q);
	assign ms_tick = (ms_div_q == 32'(MS_CYC - 1));
	assign samp_tick = (samp_q == 32'(SAMPLE_CYC - 1));
	assign stop_hit = (state_q == OTX_TRANSMIT) && !DATA_PIN && ms_tick
		&& (low_ms_q + 7'h01 >= stop_ms(CFG.stop_sel));

	always_comb begin
		state_d = state_q;
		timer_d = (timer_q != '0) ? timer_q - 32'h1 : '0;
		edge_armed_d = edge_armed_q;
		cal_d = 1'b0;
		if (ser_rst)
			edge_armed_d = 1'b0;
		else if (ser_dis)
			edge_armed_d = 1'b1;
		if (soft_rst) begin
			// Soft reset wins over every state; serial arming is kept
			state_d = OTX_SLEEP;
			cal_d = 1'b1;
		end else begin
			unique case (state_q)
				OTX_SLEEP: begin
					if (edge_armed_q && trig_edge) begin
						state_d = OTX_OSC_STARTUP;
						timer_d = 32'(XTAL_CYC - 1);
					end
				end
				OTX_OSC_STARTUP: begin
					if (timer_q == '0) begin
						state_d = OTX_TUNE;
						timer_d = 32'(TUNE_CYC - 1);
					end
				end
				OTX_TUNE: begin
					if (timer_q == '0)
						state_d = OTX_TRANSMIT;
				end
				OTX_TRANSMIT: begin
					if (stop_hit)
						state_d = OTX_SLEEP;
				end
			endcase
		end
		rf_d = rf_of(state_d);
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= OTX_SLEEP;
			rf_q <= '0;
			timer_q <= '0;
			edge_armed_q <= EDGE_ARMED_RST;
			cal_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rf_q <= rf_d;
			timer_q <= timer_d;
			edge_armed_q <= edge_armed_d;
			cal_q <= cal_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Low-time measurement and payload sampling

	always_comb begin
		ms_div_d = ms_tick ? '0 : ms_div_q + 32'h1;
		low_ms_d = low_ms_q;
		samp_d = samp_tick ? '0 : samp_q + 32'h1;
		// Any high level restarts the stop measurement from zero
		if (state_q != OTX_TRANSMIT || DATA_PIN) begin
			ms_div_d = '0;
			low_ms_d = '0;
		end else if (ms_tick) begin
			low_ms_d = low_ms_q + 7'h01;
		end
		if (state_q != OTX_TRANSMIT)
			samp_d = '0;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin_q <= 1'b0;
			ms_div_q <= '0;
			low_ms_q <= '0;
			samp_q <= '0;
		end else begin
			pin_q <= DATA_PIN;
			ms_div_q <= ms_div_d;
			low_ms_q <= low_ms_d;
			samp_q <= samp_d;
		end
	end

	// Pin level is only taken while transmitting; start-up and tune ignore it
	assign push = (state_q == OTX_TRANSMIT) && samp_tick;
	assign tx_exit = (state_q == OTX_TRANSMIT) && (state_d != OTX_TRANSMIT);
	// Leftover samples are dropped when the amplifier turns off
	assign flush = tx_exit || (state_q != OTX_TRANSMIT);

	otx_fifo #(
		.W(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.flush(flush),
		.in_valid(push),
		.in_ready(DATA_READY),
		.in_data(DATA_PIN),
		.out_valid(MOD_VALID),
		.out_ready(MOD_READY),
		.out_data(MOD_BIT)
	);

	assign RF_EN = rf_q;
	assign STATE = state_q;
	assign CAL_START = cal_q;
	assign EDGE_ARMED = edge_armed_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int XTAL_LAST = XTAL_CYC - 1;
	localparam int TUNE_LAST = TUNE_CYC - 1;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	state_legal_a: assert property (STATE inside {OTX_SLEEP, OTX_OSC_STARTUP, OTX_TUNE,
		OTX_TRANSMIT})
		else $error("state code illegal");
	sleep_all_off_a: assert property (STATE == OTX_SLEEP |-> RF_EN == '0)
		else $error("block powered in sleep");
	trig_start_a: assert property (STATE == OTX_SLEEP && EDGE_ARMED && trig_edge &&
		!CMD_VALID |=> STATE == OTX_OSC_STARTUP && RF_EN.osc_en && !RF_EN.pa_en)
		else $error("trigger edge did not start oscillator");
	startup_load_a: assert property (STATE == OTX_SLEEP ##1 STATE == OTX_OSC_STARTUP
		|-> timer_q == 32'(XTAL_LAST))
		else $error("start-up counter load wrong");
	startup_done_a: assert property (STATE == OTX_OSC_STARTUP && timer_q == '0 && !soft_rst
		|=> STATE == OTX_TUNE && timer_q == 32'(TUNE_LAST))
		else $error("start-up did not move to tune");
	pa_after_tune_a: assert property (RF_EN.pa_en |-> STATE == OTX_TRANSMIT &&
		$past(STATE) inside {OTX_TUNE, OTX_TRANSMIT})
		else $error("amplifier on before tune done");
	pin_ignored_a: assert property (STATE inside {OTX_OSC_STARTUP, OTX_TUNE}
		|=> !MOD_VALID)
		else $error("payload taken before transmit");
	stop_low_a: assert property (STATE == OTX_TRANSMIT && !DATA_PIN && ms_tick &&
		low_ms_q + 7'h01 >= stop_ms(CFG.stop_sel) && !CMD_VALID |=> STATE == OTX_SLEEP)
		else $error("low stop interval ignored");
	soft_stop_a: assert property (soft_rst |=> STATE == OTX_SLEEP && !RF_EN.pa_en &&
		CAL_START ##1 !CAL_START)
		else $error("soft reset did not stop");
	edge_arm_a: assert property (ser_rst |=> !EDGE_ARMED ##1
		(!EDGE_ARMED || $past(ser_dis)))
		else $error("serial reset left trigger armed");

	tune_done_a: assert property (STATE == OTX_TUNE && timer_q == '0 && !soft_rst
		|=> STATE == OTX_TRANSMIT && RF_EN.osc_en && RF_EN.synth_en && RF_EN.pa_en)
		else $error("tune did not move to transmit");
	startup_rf_a: assert property (STATE == OTX_OSC_STARTUP |-> RF_EN.osc_en &&
		!RF_EN.synth_en && !RF_EN.pa_en)
		else $error("start-up enables wrong");
	tune_rf_a: assert property (STATE == OTX_TUNE |-> RF_EN.osc_en && RF_EN.synth_en &&
		!RF_EN.pa_en)
		else $error("tune enables wrong");
	startup_hold_a: assert property (STATE == OTX_OSC_STARTUP && timer_q != '0 &&
		!soft_rst |=> STATE == OTX_OSC_STARTUP)
		else $error("start-up left early");
	tune_hold_a: assert property (STATE == OTX_TUNE && timer_q != '0 && !soft_rst
		|=> STATE == OTX_TUNE)
		else $error("tune left early");
	high_clears_a: assert property (STATE == OTX_TRANSMIT && DATA_PIN
		|=> low_ms_q == '0)
		else $error("high level did not restart stop count");
	no_early_stop_a: assert property (STATE == OTX_TRANSMIT && DATA_PIN && !CMD_VALID
		|=> STATE == OTX_TRANSMIT)
		else $error("transmit ended while pin high");
	disarm_hold_a: assert property (STATE == OTX_SLEEP && !EDGE_ARMED
		|=> STATE == OTX_SLEEP)
		else $error("disarmed pin started a cycle");
	dis_arms_a: assert property (ser_dis |=> EDGE_ARMED)
		else $error("serial disable did not arm trigger");
	idle_empty_a: assert property (STATE != OTX_TRANSMIT |-> !MOD_VALID)
		else $error("payload visible outside transmit");
	sample_push_a: assert property (push && DATA_READY && !tx_exit |=> MOD_VALID)
		else $error("pin sample not buffered");
	cal_only_soft_a: assert property (!soft_rst |=> !CAL_START)
		else $error("calibration without soft reset");
	soft_keep_arm_a: assert property (soft_rst |=> $stable(EDGE_ARMED))
		else $error("soft reset changed trigger arming");

	// Dwell counter, independent of the interval timer, so a wrong load shows
	logic [31:0] dwell_q, dwell_d;

	always_comb begin
		dwell_d = (state_d == state_q) ? dwell_q + 32'h1 : '0;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			dwell_q <= '0;
		else
			dwell_q <= dwell_d;
	end

	startup_len_a: assert property (STATE == OTX_OSC_STARTUP && state_d == OTX_TUNE
		|-> dwell_q == 32'(XTAL_LAST))
		else $error("start-up interval length wrong");
	tune_len_a: assert property (STATE == OTX_TUNE && state_d == OTX_TRANSMIT
		|-> dwell_q == 32'(TUNE_LAST))
		else $error("tune interval length wrong");

	reach_tx_c: cover property (STATE == OTX_TUNE ##1 STATE == OTX_TRANSMIT);
	fall_trig_c: cover property (STATE == OTX_SLEEP && !CFG.trig_rising
		##1 STATE == OTX_OSC_STARTUP);
	stop_end_c: cover property (stop_hit);
	soft_tx_c: cover property (STATE == OTX_TRANSMIT && soft_rst);
	fifo_full_c: cover property (!DATA_READY && STATE == OTX_TRANSMIT);
endmodule // otx_tx_ctrl

// ### tb/otx_host.sv
// Host model driving the transmitter data pin
`timescale 1ns/10ps
module otx_host (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'h0;
	// Hold level v for n cycles, changed just after an edge
	task lvl(input logic v, input int n);
		@(posedge clk);
		pin <= v;
		repeat (n - 1) @(posedge clk);
	endtask
	// Pin toggles before tune ends are don't-care, payload waits
	task trig(input logic rise);
		lvl(1'h1, 3);
		if (rise)
			repeat (3) begin
				lvl(1'h0, 4);
				lvl(1'h1, 4);
			end
		lvl(1'h0, 1);
	endtask
endmodule // otx_host

// ### tb/tb_top.sv
// Testbench for the transmitter state control
`timescale 1ns/10ps
module tb_top;
	import otx_pkg::*;
	localparam int XC = 20;
	localparam int TC = 20;
	localparam int MSC = 10;
	localparam int SC = 4;
	logic ref_clk, reset_n, pin, cmd_valid, mod_ready;
	logic data_ready, mod_valid, mod_bit, cal_start, edge_armed;
	logic [15:0] cmd_word;
	otx_cfg_s cfg;
	otx_rf_s rf_en;
	otx_state_e state;
	int error_cnt = 0;
	int comparisons = 0;
	otx_host otx_host_i (.clk(ref_clk), .pin(pin));
	otx_tx_ctrl #(.XTAL_CYC(XC), .TUNE_CYC(TC), .MS_CYC(MSC), .SAMPLE_CYC(SC),
		.FIFO_DEPTH(8)) otx_tx_ctrl_i (.REF_CLK(ref_clk), .RESET_N(reset_n),
		.DATA_PIN(pin), .CFG(cfg), .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word),
		.MOD_READY(mod_ready), .DATA_READY(data_ready), .MOD_VALID(mod_valid),
		.MOD_BIT(mod_bit), .RF_EN(rf_en), .STATE(state), .CAL_START(cal_start),
		.EDGE_ARMED(edge_armed));
	always #4 ref_clk = ~ref_clk;
	////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task cmd(input logic [15:0] w);
		@(posedge ref_clk);
		cmd_valid <= 1'h1;
		cmd_word <= w;
		@(posedge ref_clk);
		cmd_valid <= 1'h0;
	endtask
	// Dwell in state s must last exactly n cycles with no output
	task stage(input logic [1:0] s, input logic [2:0] rf, input int n);
		int c;
		logic v;
		c = 0;
		v = 1'h0;
		chk(state, s);
		chk(rf_en, rf);
		while (state === s && c < 2000) begin
			v = v | mod_valid;
			c++;
			@(negedge ref_clk);
		end
		chk(c, n);
		chk(v, 0);
	endtask
	task start(input logic rise);
		int n;
		n = 0;
		fork
			otx_host_i.trig(rise);
			begin
				while (state === OTX_SLEEP && n < 20) begin
					@(negedge ref_clk);
					n++;
				end
				stage(OTX_OSC_STARTUP, 3'h4, XC);
				stage(OTX_TUNE, 3'h6, TC);
				chk(rf_en, 3'h7);
			end
		join
	endtask
	// Half-length low, a high blip restarts the count, then full stop
	task stop_ms(input int ms);
		int c;
		c = 0;
		otx_host_i.lvl(1'h1, 2);
		otx_host_i.lvl(1'h0, ms * MSC / 2);
		otx_host_i.lvl(1'h1, 2);
		otx_host_i.lvl(1'h0, 1);
		while (state === OTX_TRANSMIT && c < 2000) begin
			@(negedge ref_clk);
			c++;
		end
		chk(c >= ms * MSC - 1 && c <= ms * MSC + 3, 1);
		chk(rf_en, 0);
		chk(mod_valid, 0);
	endtask
	////////////////////////////////////////
	task t_payload;
		logic [7:0] got;
		@(posedge ref_clk);
		mod_ready <= 1'h0;
		start(1'h1);
		// Each bit spans two samples whatever the phase
		for (int i = 3; i >= 0; i--) otx_host_i.lvl(i != 2, 2 * SC);
		otx_host_i.lvl(1'h0, 2 * SC);
		@(negedge ref_clk);
		chk(data_ready, 0);
		@(posedge ref_clk);
		mod_ready <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk);
			chk(mod_valid, 1);
			got = {got[6:0], mod_bit};
		end
		chk(got, 8'hcf);
		$display("payload test done");
	endtask
	task t_softrst;
		cmd(16'hbd01);
		@(negedge ref_clk);
		chk(state, OTX_SLEEP);
		chk(cal_start, 1);
		chk(rf_en, 0);
		@(negedge ref_clk);
		chk(cal_start, 0);
		$display("soft reset test done");
	endtask
	task t_stop;
		for (int s = 0; s < 8; s++) begin
			@(posedge ref_clk);
			cfg <= '{1'h1, s[2:0]};
			start(1'h1);
			stop_ms(20 + 10 * s);
		end
		$display("stop test done");
	endtask
	task t_fall;
		@(posedge ref_clk);
		cfg <= '{1'h0, 3'h1};
		otx_host_i.lvl(1'h1, 4);
		@(negedge ref_clk);
		chk(state, OTX_SLEEP);
		start(1'h0);
		stop_ms(30);
		$display("falling test done");
	endtask
	task t_arm;
		@(posedge ref_clk);
		cfg <= '{1'h1, 3'h0};
		cmd(16'h8d00);
		@(negedge ref_clk);
		chk(edge_armed, 0);
		otx_host_i.lvl(1'h1, 4);
		cmd(16'h1234);
		@(negedge ref_clk);
		chk(state, OTX_SLEEP);
		chk(edge_armed, 0);
		otx_host_i.lvl(1'h0, 2);
		cmd(16'h8d02);
		@(negedge ref_clk);
		chk(edge_armed, 1);
		start(1'h1);
		$display("arm test done");
	endtask
	////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge ref_clk);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		ref_clk = 1'h0;
		reset_n = 1'h0;
		cfg = '{1'h1, 3'h0};
		cmd_valid = 1'h0;
		cmd_word = 16'h0000;
		mod_ready = 1'h1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(state, OTX_SLEEP);
		chk(rf_en, 0);
		chk(edge_armed, 1);
		chk(data_ready, 1);
		chk(mod_valid, 0);
		@(posedge ref_clk);
		reset_n <= 1'h1;
		t_payload;
		t_softrst;
		t_stop;
		t_fall;
		t_arm;
		t_softrst;
		tally_and_finish;
	end
endmodule // tb_top
